// ==== dv/keypad_model.sv ====
// Electronic key driver standing in front of the key decode logic
module keypad_model (
   input  wire logic [dtmf_pkg::LINES-1:0] row_press_i,
   input  wire logic [dtmf_pkg::LINES-1:0] col_press_i,
   output logic      [dtmf_pkg::LINES-1:0] row_n_o,
   output logic      [dtmf_pkg::LINES-1:0] col_n_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import dtmf_pkg::*;
   // Driven lines pull low; idle lines sit at the pull-up level.
   // Electronic drive keeps acting while the keyboard pulls are off.
   assign row_n_o = ~row_press_i;
   assign col_n_o = ~col_press_i;
endmodule

// ==== dv/tb.sv ====
// Self-checking testbench for the DTMF key decode and tone selection logic
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dtmf_pkg::*;
   logic             ref_clk_i = 1'b0;
   logic             rst_b_i = 1'b0;
   logic             clk_en_i = 1'b1;
   logic             part_inhibit_n_i = 1'b1;
   logic             dual_only_select_n_i = 1'b1;
   logic [LINES-1:0] row_press = '0;
   logic [LINES-1:0] col_press = '0;
   logic [LINES-1:0] row_n, col_n;
   logic             mute_o, osc_stop_o, kbd_oe_o, scan_row_o, row_tone_on_o, col_tone_on_o;
   logic [TAP_W-1:0] row_tap_o, col_tap_o;
   int               mismatches = 0;
   int               total_checks = 0;
   int               cycles = 0;

   keypad_model i_keys (.row_press_i(row_press), .col_press_i(col_press),
                        .row_n_o(row_n), .col_n_o(col_n));
   dtmf_keypad_logic i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
      .row_n_i(row_n), .col_n_i(col_n), .part_inhibit_n_i(part_inhibit_n_i),
      .dual_only_select_n_i(dual_only_select_n_i), .mute_o(mute_o), .osc_stop_o(osc_stop_o),
      .kbd_oe_o(kbd_oe_o), .scan_row_o(scan_row_o), .row_tone_on_o(row_tone_on_o),
      .col_tone_on_o(col_tone_on_o), .row_tap_o(row_tap_o), .col_tap_o(col_tap_o));

   always #5 ref_clk_i = ~ref_clk_i;
   // Longest scenario is the tone timing, well under this ceiling
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 100000) begin
         mismatches++;
         report_and_stop();
      end
   end

   // ****************************************
   // Compare tasks
   // ****************************************
   task automatic chk_state(input logic [4:0] exp, input string what);
      logic [4:0] got;
      got = {mute_o, osc_stop_o, kbd_oe_o, row_tone_on_o, col_tone_on_o};
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s state %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic chk_taps(input logic [8:0] exp, input string what);
      total_checks++;
      if ({scan_row_o, row_tap_o, col_tap_o} !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s strobe/taps %h expected %h", $time, what,
                  {scan_row_o, row_tap_o, col_tap_o}, exp);
      end
   endtask
   task automatic chk_near(input int got, input int exp, input string what);
      total_checks++;
      if (got > exp + 3 || got < exp - 3) begin
         mismatches++;
         $display("[FAIL] %0t %s interval %0d expected %0d", $time, what, got, exp);
      end
   endtask

   // ****************************************
   // Stimulus helpers
   // ****************************************
   task automatic apply(input logic [LINES-1:0] r, input logic [LINES-1:0] c);
      @(posedge ref_clk_i);
      #1;
      row_press = r;
      col_press = c;
      repeat (2) @(posedge ref_clk_i);
      #1;
   endtask
   function automatic logic [TAP_W-1:0] tap(input bit col);
      return col ? col_tap_o : row_tap_o;
   endfunction
   // Times one tap change to the next; the first change may be tone start
   task automatic measure(input bit col, input int f, input string what);
      int t0, t1, w, n;
      real step;
      logic [TAP_W-1:0] last;
      step = real'((REF_HZ + f * 16) / (f * 32)) * real'(CLK_HZ) / real'(REF_HZ);
      for (int k = 0; k < 3; k++) begin
         last = tap(col);
         w = 0;
         while (tap(col) === last && w < 40000) begin
            @(posedge ref_clk_i);
            #1;
            w++;
         end
         if (k == 1) t0 = cycles;
         if (k == 2) t1 = cycles;
      end
      n = int'(real'(t1 - t0) / step);
      if (n < 1) n = 1;
      chk_near(t1 - t0, int'(n * step), what);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_single_keys();
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < 4; c++) begin
            apply(4'h1 << r, 4'h1 << c);
            chk_state(5'b10111, "single key");
         end
      end
      apply(4'h0, 4'h0);
      chk_state(5'b01100, "no key");
      chk_taps(9'h188, "no key");
   endtask
   task automatic t_multi_keys();
      logic [12:0] tbl [6] = '{13'h1315, 13'h1166, 13'h15a4,
                              13'h0314, 13'h0164, 13'h0117};
      foreach (tbl[i]) begin
         dual_only_select_n_i = tbl[i][12];
         apply(tbl[i][11:8], tbl[i][7:4]);
         chk_state({1'b1, tbl[i][3:0]}, "multi key");
      end
      apply(4'h5, 4'ha);
      chk_taps({scan_row_o, 8'h88}, "diagonal keys");
      dual_only_select_n_i = 1'b1;
      apply(4'h0, 4'h1);
      chk_state(5'b10100, "column only");
      clk_en_i = 1'b0;
      apply(4'h1, 4'h1);
      chk_state(5'b10100, "clock held");
      clk_en_i = 1'b1;
      part_inhibit_n_i = 1'b0;
      apply(4'h1, 4'h1);
      chk_state(5'b01000, "inhibited key");
      chk_taps(9'h188, "inhibited key");
      part_inhibit_n_i = 1'b1;
      apply(4'h1, 4'h1);
      chk_state(5'b10111, "inhibit lifted");
   endtask
   task automatic t_tone_rates();
      for (int i = 0; i < 4; i += 3) begin
         apply(4'h1 << i, 4'h1 << i);
         measure(1'b0, LOW_HZ[i], "row tone");
         measure(1'b1, HIGH_HZ[i], "column tone");
         apply(4'h0, 4'h0);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge ref_clk_i);
      #1;
      chk_state(5'b01000, "in reset");
      chk_taps(9'h188, "in reset");
      rst_b_i = 1'b1;
      t_single_keys();
      t_multi_keys();
      t_tone_rates();
      report_and_stop();
   end
endmodule

// ==== verilog/dtmf_keypad_logic.sv ====
// Key decode, tone selection and sine tap sequencing of a DTMF dialer
module dtmf_keypad_logic #(
   parameter int unsigned CLK_FREQ = dtmf_pkg::CLK_HZ
) (
   input  wire logic                        ref_clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic                        clk_en_i,
   input  wire logic [dtmf_pkg::LINES-1:0]  row_n_i,
   input  wire logic [dtmf_pkg::LINES-1:0]  col_n_i,
   input  wire logic                        part_inhibit_n_i,
   input  wire logic                        dual_only_select_n_i,
   output logic                             mute_o,
   output logic                             osc_stop_o,
   output logic                             kbd_oe_o,
   output logic                             scan_row_o,
   output logic                             row_tone_on_o,
   output logic                             col_tone_on_o,
   output logic [dtmf_pkg::TAP_W-1:0]       row_tap_o,
   output logic [dtmf_pkg::TAP_W-1:0]       col_tap_o
);
   import dtmf_pkg::*;

   if (CLK_FREQ <= REF_HZ || CLK_FREQ >= (1 << (ACC_W - 1))) begin : g_bad_clk
      $error("CLK_FREQ must exceed the reference and fit the accumulator");
   end

   localparam logic [DIV_W-1:0] LOW_DIV  [4] = '{div_of(LOW_HZ[0]), div_of(LOW_HZ[1]),
                                                 div_of(LOW_HZ[2]), div_of(LOW_HZ[3])};
   localparam logic [DIV_W-1:0] HIGH_DIV [4] = '{div_of(HIGH_HZ[0]), div_of(HIGH_HZ[1]),
                                                 div_of(HIGH_HZ[2]), div_of(HIGH_HZ[3])};
   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(REF_HZ);
   localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_FREQ);

   // ************************************************************
   // Key decode
   // ************************************************************
   logic [LINES-1:0] rows;
   logic [LINES-1:0] cols;
   logic [2:0]       nr;
   logic [2:0]       nc;
   logic             next_sensed;
   logic             next_row_on;
   logic             next_col_on;
   logic [IDX_W-1:0] next_row_idx;
   logic [IDX_W-1:0] next_col_idx;
   logic [IDX_W-1:0] row_idx;
   logic [IDX_W-1:0] col_idx;

   always_comb begin
      rows         = ~row_n_i;
      cols         = ~col_n_i;
      nr           = 3'($countones(rows));
      nc           = 3'($countones(cols));
      // Inhibit acts only when pulled low; an open pin reads high
      next_sensed  = part_inhibit_n_i && ((|rows) || (|cols));
      next_row_on  = part_inhibit_n_i && nr == 3'h1 &&
                     (nc == 3'h1 || (nc >= 3'h2 && dual_only_select_n_i));
      next_col_on  = part_inhibit_n_i && nc == 3'h1 &&
                     (nr == 3'h1 || (nr >= 3'h2 && dual_only_select_n_i));
      next_row_idx = row_idx;
      next_col_idx = col_idx;
      // Lowest active line wins; only matters when exactly one is active
      for (int i = LINES - 1; i >= 0; i--) begin
         if (rows[i]) begin
            next_row_idx = IDX_W'(i);
         end
         if (cols[i]) begin
            next_col_idx = IDX_W'(i);
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         mute_o        <= 1'b0;
         osc_stop_o    <= OSC_STOP_RST;
         kbd_oe_o      <= 1'b0;
         row_tone_on_o <= 1'b0;
         col_tone_on_o <= 1'b0;
         row_idx       <= '0;
         col_idx       <= '0;
      end else if (clk_en_i) begin
         mute_o        <= next_sensed;
         osc_stop_o    <= !next_sensed;
         kbd_oe_o      <= part_inhibit_n_i;
         row_tone_on_o <= next_row_on;
         col_tone_on_o <= next_col_on;
         row_idx       <= next_row_idx;
         col_idx       <= next_col_idx;
      end
   end

   // ************************************************************
   // Reference oscillator stand-in
   // ************************************************************
   // Fractional accumulator turns the fast clock into reference ticks,
   // trading a little jitter for exact average crystal rate.
   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] next_acc;
   logic             ref_tick;
   logic             next_ref_tick;

   always_comb begin
      next_acc      = '0;
      next_ref_tick = 1'b0;
      if (!osc_stop_o) begin
         next_acc = acc + ACC_STEP;
         if (next_acc >= ACC_WRAP) begin
            next_acc      = next_acc - ACC_WRAP;
            next_ref_tick = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         acc      <= '0;
         ref_tick <= 1'b0;
      end else if (clk_en_i) begin
         acc      <= next_acc;
         ref_tick <= next_ref_tick;
      end
   end

   // ************************************************************
   // Tone dividers and phase stepping, group 0 rows, group 1 columns
   // ************************************************************
   logic [DIV_W-1:0] cnt  [2];
   logic [PH_W-1:0]  ph   [2];
   logic [TAP_W-1:0] tap  [2];
   logic [DIV_W-1:0] div  [2];
   logic             on   [2];
   logic             wrap [2];

   assign div[0] = LOW_DIV[row_idx];
   assign div[1] = HIGH_DIV[col_idx];
   assign on[0]  = row_tone_on_o;
   assign on[1]  = col_tone_on_o;

   for (genvar g = 0; g < 2; g++) begin : g_grp
      logic [DIV_W-1:0] next_cnt;
      logic [PH_W-1:0]  next_ph;
      logic [TAP_W-1:0] next_tap;

      always_comb begin
         next_cnt = cnt[g];
         next_ph  = ph[g];
         wrap[g]  = 1'b0;
         // Dividers run whenever the oscillator runs so the strobe keeps time
         if (osc_stop_o) begin
            next_cnt = '0;
            next_ph  = '0;
         end else if (ref_tick) begin
            if (cnt[g] >= div[g] - DIV_W'(1)) begin
               next_cnt = '0;
               next_ph  = ph[g] + PH_W'(1);
               wrap[g]  = (ph[g] == PH_W'(STEPS - 1));
            end else begin
               next_cnt = cnt[g] + DIV_W'(1);
            end
         end
         next_tap = on[g] ? SINE_TAPS[next_ph * TAP_W +: TAP_W]
                          : SINE_TAPS[0 +: TAP_W];
      end

      always_ff @(posedge ref_clk_i) begin
         if (!rst_b_i) begin
            cnt[g] <= '0;
            ph[g]  <= '0;
            tap[g] <= SINE_TAPS[0 +: TAP_W];
         end else if (clk_en_i) begin
            cnt[g] <= next_cnt;
            ph[g]  <= next_ph;
            tap[g] <= next_tap;
         end
      end
   end

   assign row_tap_o = tap[0];
   assign col_tap_o = tap[1];

   // ************************************************************
   // Keyboard strobe
   // ************************************************************
   logic next_scan;

   always_comb begin
      next_scan = scan_row_o;
      if (osc_stop_o) begin
         next_scan = SCAN_ROW_RST;
      end else if (wrap[0]) begin
         next_scan = !scan_row_o;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         scan_row_o <= SCAN_ROW_RST;
      end else if (clk_en_i) begin
         scan_row_o <= next_scan;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   logic one_row;
   logic one_col;
   assign one_row = $onehot(~row_n_i);
   assign one_col = $onehot(~col_n_i);

   a_inhibit_no_tone: assert property (clk_en_i && !part_inhibit_n_i |=>
      !row_tone_on_o && !col_tone_on_o && !kbd_oe_o)
      else $error("tone or keyboard drive while inhibited");
   a_open_inhibit_runs: assert property (clk_en_i && part_inhibit_n_i && one_row && one_col
      |=> mute_o && kbd_oe_o)
      else $error("inhibit high did not run normally");
   a_need_row_col: assert property (clk_en_i && (&row_n_i || &col_n_i) |=>
      !row_tone_on_o && !col_tone_on_o)
      else $error("tone without both a row and a column");
   a_single_key_dual: assert property (clk_en_i && part_inhibit_n_i && one_row && one_col
      |=> row_tone_on_o && col_tone_on_o)
      else $error("single key did not give dual tone");
   a_multi_row_col: assert property (clk_en_i && part_inhibit_n_i && dual_only_select_n_i
      && $countones(~row_n_i) >= 2 && one_col |=> col_tone_on_o && !row_tone_on_o)
      else $error("multi row did not give column tone only");
   a_diagonal_none: assert property (clk_en_i && $countones(~row_n_i) >= 2
      && $countones(~col_n_i) >= 2 |=> !row_tone_on_o && !col_tone_on_o)
      else $error("diagonal keys gave a tone");
   // A key change may leave the count above a smaller ratio until the
   // next tick clears it, so the bound is checked right after a tick only.
   a_row_divider: assert property (clk_en_i && !osc_stop_o && ref_tick |=>
      cnt[0] < $past(LOW_DIV[row_idx]))
      else $error("row divider past its ratio");
   a_col_divider: assert property (clk_en_i && !osc_stop_o && ref_tick |=>
      cnt[1] < $past(HIGH_DIV[col_idx]))
      else $error("column divider past its ratio");
   a_osc_stops: assert property (clk_en_i && &row_n_i && &col_n_i |=> osc_stop_o
      ##1 !ref_tick)
      else $error("oscillator ran with no key");
   a_mute_follows: assert property (clk_en_i && part_inhibit_n_i |=> mute_o == !osc_stop_o
      && mute_o == $past(!(&row_n_i && &col_n_i)))
      else $error("mute does not follow key sensing");
   a_mute_no_tone: assert property (clk_en_i && part_inhibit_n_i && !dual_only_select_n_i
      && !row_n_i[0] && !row_n_i[1] && one_col |=> mute_o && !col_tone_on_o)
      else $error("mute did not switch on a toneless key");
   a_mute_inhibit: assert property (clk_en_i && !part_inhibit_n_i |=> !mute_o)
      else $error("mute moved while inhibited");
   a_dual_only: assert property (clk_en_i && !dual_only_select_n_i &&
      ($countones(~row_n_i) >= 2 || $countones(~col_n_i) >= 2)
      |=> !row_tone_on_o && !col_tone_on_o)
      else $error("single tone while dual-only selected");
   a_scan_idle: assert property (osc_stop_o && clk_en_i |=> scan_row_o)
      else $error("strobe not static when idle");
   a_phase_step: assert property (clk_en_i && !osc_stop_o && ref_tick &&
      cnt[1] == div[1] - DIV_W'(1) && !osc_stop_o |=> ph[1] == $past(ph[1]) + PH_W'(1)
      || osc_stop_o)
      else $error("column phase did not step");

   // Keyboard pulls track inhibit with one cycle of latency
   a_kbd_follows: assert property (clk_en_i |=> kbd_oe_o == $past(part_inhibit_n_i))
      else $error("keyboard drive does not follow inhibit");
   a_osc_restart: assert property (clk_en_i && part_inhibit_n_i &&
      !(&row_n_i && &col_n_i) |=> !osc_stop_o)
      else $error("oscillator did not start on a key");
   a_acc_bound: assert property (acc < ACC_WRAP)
      else $error("reference accumulator out of range");
   a_row_phase_step: assert property (clk_en_i && !osc_stop_o && ref_tick &&
      cnt[0] >= div[0] - DIV_W'(1) |=> ph[0] == $past(ph[0]) + PH_W'(1))
      else $error("row phase did not step");
   // Idle taps sit at mid code so the converter output stays quiet
   a_row_tap_idle: assert property (clk_en_i && !row_tone_on_o |=>
      row_tap_o == SINE_TAPS[0 +: TAP_W])
      else $error("row tap moved with tone off");
   a_col_tap_idle: assert property (clk_en_i && !col_tone_on_o |=>
      col_tap_o == SINE_TAPS[0 +: TAP_W])
      else $error("column tap moved with tone off");
   a_scan_toggle: assert property (clk_en_i && !osc_stop_o && wrap[0] |=>
      scan_row_o != $past(scan_row_o))
      else $error("strobe did not alternate on row wrap");

   c_inhibit:     cover property (!part_inhibit_n_i ##1 !kbd_oe_o);
   c_dual_tone:   cover property (row_tone_on_o && col_tone_on_o ##1 row_tap_o != $past(row_tap_o));
   c_col_only:    cover property (col_tone_on_o && !row_tone_on_o);
   c_row_only:    cover property (row_tone_on_o && !col_tone_on_o);
   c_scan_toggle: cover property (!osc_stop_o && $changed(scan_row_o));
endmodule

// ==== verilog/dtmf_pkg.sv ====
// Constants for the DTMF tone dialer key decode and tone selection logic
//
// Functional notes
// - Inhibit low: no tones, keyboard pulls released, oscillator and amplifiers off.
// - Inhibit input pulled up: floating or high means normal operation.
// - A tone needs at least one row and one column active together.
// - One row and one column give both matching group tones.
// - Many rows plus one column give column tone; reverse gives row tone.
// - Two or more rows and two or more columns give no tone.
// - Each key selects divide ratios of the crystal reference for its tones.
// - Rows map 697/770/852/941 Hz; columns 1209/1336/1477/1633 Hz.
// - Reference oscillator stops with no key sensed, restarts on key input.
// - Keypress indicator low with no key, high while a key is sensed.
// - Indicator follows sensing regardless of dual-only select or tone result.
// - With inhibit low, indicator ignores keys and stays at no-key level.
// - Dual-only select pulled up; low kills any multi-row or multi-column tone.
// - Sensing strobes rows and columns alternately near row rate; idle senses rows.
package dtmf_pkg;
   localparam int unsigned CLK_HZ       = 100_000_000;
   localparam int unsigned REF_HZ       = 3_579_545;
   localparam int unsigned LINES        = 4;
   localparam int unsigned IDX_W        = 2;
   localparam int unsigned STEPS        = 32;
   localparam int unsigned PH_W         = 5;
   localparam int unsigned DIV_W        = 8;
   localparam int unsigned TAP_W        = 4;
   localparam int unsigned ACC_W        = 28;
   localparam int unsigned LOW_HZ  [4]  = '{697, 770, 852, 941};
   localparam int unsigned HIGH_HZ [4]  = '{1209, 1336, 1477, 1633};
   // Sine tap codes, entry 0 in the low nibble
   localparam logic [127:0] SINE_TAPS   = 128'h75432111_11234578_9bcdefff_ffedcb98;
   localparam logic        OSC_STOP_RST = 1'b1;
   localparam logic        SCAN_ROW_RST = 1'b1;

   // Reference ticks per phase step, rounded to nearest
   function automatic logic [DIV_W-1:0] div_of(input int unsigned f);
      return DIV_W'((REF_HZ + f * STEPS / 2) / (f * STEPS));
   endfunction
endpackage
